// ### hw/clock_source_startup_control.sv
/*
 Clock source selection, start-up reset sequencing, divide-by-eight and domain gating.
 Assumes oscillator, watchdog, timer crystal, wake and reset pins are asynchronous levels
 sampled on clk (each oscillator far slower than clk), and APB master timing per the bus.
*/
// Functional notes
// - Unused domain clocks stop according to the selected sleep mode.
// - Core clock stops in every sleep mode, so the core does nothing.
// - Peripheral clock drives I/O; async wake pin still detected when halted.
// - Flash interface clock ticks exactly together with the core clock.
// - Async timer clock comes from its own pin and keeps running in sleep, except in power-down and standby.
// - Converter clock is its own domain, alive in noise-reduction sleep.
// - Codes 1xxx low power, 011x full swing, 010x low frequency crystal.
// - 0011 is 128 kHz RC, 0010 calibrated RC, 0000 external; 0001 reserved.
// - Fuse bits are inverted: zero means programmed.
// - Default fuses: calibrated RC, time-out max, divide by eight programmed.
// - Internal reset stays asserted a time-out after other resets release.
// - Time-out counts 0, 512 or 8192 watchdog cycles chosen by fuses.
// - Time-out is a pure count and never senses supply voltage.
// - Counter on selected oscillator holds reset for start-up cycles, then releases.
// - Start-up count ranges from 6 external cycles to 32K low frequency.
// - Reset start uses both delays; power-save/down wake uses start-up only.
// - Programmed divide fuse divides the system clock by eight.
`timescale 1ns/10ps
`default_nettype none
module clock_source_startup_control #(
   parameter int TOUT_LONG_CYC = clock_ctrl_pkg::TOUT_LONG,
   parameter int START_16K_CYC = clock_ctrl_pkg::START_16K,
   parameter int START_32K_CYC = clock_ctrl_pkg::START_32K
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [clock_ctrl_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [clock_ctrl_pkg::NUM_SRC-1:0] oscillator_amp_input,
   input wire logic watchdogOsc,
   input wire logic asyncTimerOsc,
   input wire logic asyncWake,
   input wire logic resetSource,
   output logic internalReset,
   output clock_ctrl_pkg::clk_ticks_t clockTicks
);
   logic [clock_ctrl_pkg::NUM_PINS-1:0] syncA;
   logic [clock_ctrl_pkg::NUM_PINS-1:0] syncB;
   logic [clock_ctrl_pkg::NUM_PINS-1:0] syncC;
   logic [clock_ctrl_pkg::NUM_PINS-1:0] rise;
   clock_ctrl_pkg::fuse_t fuseReg;
   clock_ctrl_pkg::fuse_t activeFuse;
   clock_ctrl_pkg::ctl_state_t state;
   logic [2:0] sleepMode;
   logic sleepGo;
   logic restart;
   logic [clock_ctrl_pkg::CNT_W-1:0] cnt;
   logic [2:0] divCnt;
   int selSrc;
   logic srcEdge;
   logic sysTick;
   logic rstReq;
   logic divEight;
   logic apbSetup;
   logic apbDone;
   logic [31:0] readMux;
   logic mapped;

   // Time-out length by source type and start-up fuses
   function automatic logic [clock_ctrl_pkg::CNT_W-1:0] timeoutLoad(input clock_ctrl_pkg::fuse_t f);
      logic [2:0] idx;
      int n;
      idx = {f.srcSel[0], f.startFuse};
      n = 0;
      if (f.srcSel[3] || f.srcSel[3:1] == 3'h3) begin
         case (idx)
            3'h0, 3'h3, 3'h6: n = clock_ctrl_pkg::TOUT_SHORT;
            3'h1, 3'h4, 3'h7: n = TOUT_LONG_CYC;
            default: n = 0;
         endcase
      end else begin
         case (f.startFuse)
            2'h0: n = 0;
            2'h1: n = clock_ctrl_pkg::TOUT_SHORT;
            default: n = TOUT_LONG_CYC;
         endcase
      end
      return n[clock_ctrl_pkg::CNT_W-1:0];
   endfunction

   // Oscillator start-up count by clock type
   function automatic logic [clock_ctrl_pkg::CNT_W-1:0] startupLoad(input clock_ctrl_pkg::fuse_t f);
      logic [2:0] idx;
      int n;
      idx = {f.srcSel[0], f.startFuse};
      n = clock_ctrl_pkg::START_EXT;
      if (f.srcSel[3] || f.srcSel[3:1] == 3'h3) begin
         case (idx)
            3'h0, 3'h1: n = clock_ctrl_pkg::START_258;
            3'h2, 3'h3, 3'h4: n = clock_ctrl_pkg::START_1K;
            default: n = START_16K_CYC;
         endcase
      end else if (f.srcSel[3:1] == 3'h2) begin
         n = START_32K_CYC;
      end
      // Loads above 65535 are clamped to the counter top; the full 32K load fits the 16-bit counter unchanged
      if (n > 65535) begin
         n = 65535;
      end
      return n[clock_ctrl_pkg::CNT_W-1:0];
   endfunction

   // Two-stage synchronisers, third stage only for edge detection
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         syncA <= '0;
         syncB <= '0;
         syncC <= '0;
      end else begin
         syncA <= {resetSource, asyncWake, asyncTimerOsc, watchdogOsc, oscillator_amp_input};
         syncB <= syncA;
         syncC <= syncB;
      end
   end
   assign rise = syncB & ~syncC;

   // Source multiplexer from the latched fuse code
   always_comb begin
      if (activeFuse.srcSel[3]) begin
         selSrc = clock_ctrl_pkg::SRC_LP;
      end else if (activeFuse.srcSel[3:1] == 3'h3) begin
         selSrc = clock_ctrl_pkg::SRC_FS;
      end else if (activeFuse.srcSel[3:1] == 3'h2) begin
         selSrc = clock_ctrl_pkg::SRC_LF;
      end else if (activeFuse.srcSel == clock_ctrl_pkg::SRC_CODE_RC128) begin
         selSrc = clock_ctrl_pkg::SRC_RC128;
      end else if (activeFuse.srcSel == clock_ctrl_pkg::SRC_CODE_EXT) begin
         selSrc = clock_ctrl_pkg::SRC_EXT;
      end else begin
         selSrc = clock_ctrl_pkg::SRC_RCCAL;
      end
   end
   assign srcEdge = rise[selSrc];
   assign rstReq = syncB[clock_ctrl_pkg::PIN_RST] | restart;
   assign divEight = (activeFuse.divFuse == clock_ctrl_pkg::FUSE_PROGRAMMED);
   // Divided tick; with the fuse unprogrammed every source edge ticks
   assign sysTick = srcEdge && (!divEight || divCnt == 3'(clock_ctrl_pkg::DIV_LAST));

   // Reset sequencing state machine
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= clock_ctrl_pkg::ST_HOLD;
         cnt <= '0;
         activeFuse <= clock_ctrl_pkg::FUSE_DEFAULT;
      end else if (rstReq) begin
         state <= clock_ctrl_pkg::ST_HOLD;
      end else begin
         case (state)
            clock_ctrl_pkg::ST_HOLD: begin
               // Fuses take effect only on a fresh start-up
               activeFuse <= fuseReg;
               if (timeoutLoad(fuseReg) == '0) begin
                  state <= clock_ctrl_pkg::ST_STARTUP;
                  cnt <= startupLoad(fuseReg);
               end else begin
                  state <= clock_ctrl_pkg::ST_TIMEOUT;
                  cnt <= timeoutLoad(fuseReg);
               end
            end
            clock_ctrl_pkg::ST_TIMEOUT: begin
               // Counts watchdog edges only; no supply sensing
               if (rise[clock_ctrl_pkg::PIN_WDT]) begin
                  if (cnt == 16'h0001) begin
                     state <= clock_ctrl_pkg::ST_STARTUP;
                     cnt <= startupLoad(activeFuse);
                  end else begin
                     cnt <= cnt - 16'h0001;
                  end
               end
            end
            clock_ctrl_pkg::ST_STARTUP: begin
               if (srcEdge) begin
                  if (cnt <= 16'h0001) begin
                     state <= clock_ctrl_pkg::ST_RUN;
                     cnt <= '0;
                  end else begin
                     cnt <= cnt - 16'h0001;
                  end
               end
            end
            clock_ctrl_pkg::ST_RUN: begin
               if (sleepGo) begin
                  state <= clock_ctrl_pkg::ST_SLEEP;
               end
            end
            clock_ctrl_pkg::ST_SLEEP: begin
               // Wake pin seen without the peripheral clock
               if (rise[clock_ctrl_pkg::PIN_WAKE]) begin
                  if (sleepMode == clock_ctrl_pkg::SLP_PDOWN || sleepMode == clock_ctrl_pkg::SLP_PSAVE) begin
                     state <= clock_ctrl_pkg::ST_STARTUP;
                     cnt <= startupLoad(activeFuse);
                  end else begin
                     state <= clock_ctrl_pkg::ST_RUN;
                  end
               end
            end
            default: state <= clock_ctrl_pkg::ST_HOLD;
         endcase
      end
   end

   // Internal reset output, high until the start-up count ends
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         internalReset <= 1'b1;
      end else begin
         internalReset <= rstReq || !(state == clock_ctrl_pkg::ST_RUN || state == clock_ctrl_pkg::ST_SLEEP);
      end
   end

   // Prescaler runs only once the source is stable
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         divCnt <= '0;
      end else if (!(state == clock_ctrl_pkg::ST_RUN || state == clock_ctrl_pkg::ST_SLEEP)) begin
         divCnt <= '0;
      end else if (srcEdge) begin
         divCnt <= divCnt + 3'h1;
      end
   end

   // Domain gating per sleep mode; all domains off while reset is held
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         clockTicks <= '0;
      end else if (state == clock_ctrl_pkg::ST_RUN) begin
         clockTicks.core <= sysTick;
         clockTicks.flash <= sysTick;
         clockTicks.periph <= sysTick;
         clockTicks.converter <= sysTick;
         clockTicks.asyncTimer <= rise[clock_ctrl_pkg::PIN_ASY];
      end else if (state == clock_ctrl_pkg::ST_SLEEP) begin
         clockTicks.core <= 1'b0;
         clockTicks.flash <= 1'b0;
         clockTicks.periph <= sysTick && sleepMode == clock_ctrl_pkg::SLP_IDLE;
         clockTicks.converter <= sysTick && (sleepMode == clock_ctrl_pkg::SLP_IDLE ||
                                             sleepMode == clock_ctrl_pkg::SLP_ADCNR);
         // Timer crystal keeps counting except in the deepest modes
         clockTicks.asyncTimer <= rise[clock_ctrl_pkg::PIN_ASY] &&
                                  sleepMode != clock_ctrl_pkg::SLP_PDOWN &&
                                  sleepMode != clock_ctrl_pkg::SLP_STANDBY;
      end else begin
         clockTicks <= '0;
      end
   end

   // APB slave: one wait state, answer registered
   assign apbSetup = psel && penable && !pready;
   assign apbDone = psel && penable && pready;
   always_comb begin
      readMux = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr)
         clock_ctrl_pkg::REG_FUSE: readMux = {25'h0, fuseReg};
         clock_ctrl_pkg::REG_CTRL: readMux = {29'h0, sleepMode};
         clock_ctrl_pkg::REG_STATUS: readMux = {20'h0, activeFuse, internalReset, 1'b0, state};
         default: mapped = 1'b0;
      endcase
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (apbSetup) begin
         pready <= 1'b1;
         pslverr <= !mapped || (pwrite && paddr == clock_ctrl_pkg::REG_STATUS);
         prdata <= pwrite ? 32'h0000_0000 : readMux;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
   end

   // Writable registers; sleep and restart requests are one-cycle pulses
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fuseReg <= clock_ctrl_pkg::FUSE_DEFAULT;
         sleepMode <= clock_ctrl_pkg::MODE_RESET;
         sleepGo <= 1'b0;
         restart <= 1'b0;
      end else begin
         sleepGo <= 1'b0;
         restart <= 1'b0;
         if (apbDone && pwrite && paddr == clock_ctrl_pkg::REG_FUSE) begin
            fuseReg <= pwdata[6:0];
         end
         if (apbDone && pwrite && paddr == clock_ctrl_pkg::REG_CTRL) begin
            sleepMode <= pwdata[clock_ctrl_pkg::CTRL_MODE_LSB +: 3];
            sleepGo <= pwdata[clock_ctrl_pkg::CTRL_SLEEP_BIT];
            restart <= pwdata[clock_ctrl_pkg::CTRL_RESTART_BIT];
         end
      end
   end

   // Checks
   AST_CORE_FLASH: assert property (@(posedge clk) disable iff (sys_rst) clockTicks.core == clockTicks.flash)
      else $error("flash clock differs from core clock");
   AST_SLEEP_NO_CORE: assert property (@(posedge clk) disable iff (sys_rst)
      state == clock_ctrl_pkg::ST_SLEEP ##1 state == clock_ctrl_pkg::ST_SLEEP |-> !clockTicks.core)
      else $error("core clock ticked in sleep");
   AST_PDOWN_GATED: assert property (@(posedge clk) disable iff (sys_rst)
      state == clock_ctrl_pkg::ST_SLEEP && sleepMode == clock_ctrl_pkg::SLP_PDOWN |=>
      !clockTicks.periph && !clockTicks.converter && !clockTicks.asyncTimer)
      else $error("domain clock ticked in power-down");
   AST_ADCNR: assert property (@(posedge clk) disable iff (sys_rst)
      state == clock_ctrl_pkg::ST_SLEEP && sleepMode == clock_ctrl_pkg::SLP_ADCNR && sysTick && !rstReq |=>
      clockTicks.converter && !clockTicks.periph)
      else $error("converter domain wrong in noise reduction");
   AST_PSAVE_ASYNC: assert property (@(posedge clk) disable iff (sys_rst)
      state == clock_ctrl_pkg::ST_SLEEP && sleepMode == clock_ctrl_pkg::SLP_PSAVE &&
      rise[clock_ctrl_pkg::PIN_ASY] && !rstReq |=> clockTicks.asyncTimer)
      else $error("async timer stopped in power-save");
   AST_DIV8_SPACING: assert property (@(posedge clk) disable iff (sys_rst)
      clockTicks.core && divEight |=> !clockTicks.core [*8])
      else $error("core tick closer than eight source edges");
   AST_NODIV: assert property (@(posedge clk) disable iff (sys_rst)
      state == clock_ctrl_pkg::ST_RUN && srcEdge && !divEight && !rstReq |=> clockTicks.core)
      else $error("undivided source edge lost");
   AST_RESERVED: assert property (@(posedge clk) disable iff (sys_rst)
      activeFuse.srcSel == clock_ctrl_pkg::SRC_CODE_RSVD |-> selSrc == clock_ctrl_pkg::SRC_RCCAL)
      else $error("reserved code not on calibrated RC");
   AST_LP_SELECT: assert property (@(posedge clk) disable iff (sys_rst)
      activeFuse.srcSel[3] |-> selSrc == clock_ctrl_pkg::SRC_LP)
      else $error("low power crystal not selected");
   AST_TIMEOUT_WDT: assert property (@(posedge clk) disable iff (sys_rst)
      state == clock_ctrl_pkg::ST_TIMEOUT && !rise[clock_ctrl_pkg::PIN_WDT] && !rstReq |=>
      state == clock_ctrl_pkg::ST_TIMEOUT && $stable(cnt))
      else $error("time-out advanced without watchdog edge");
   AST_WAKE_NO_TOUT: assert property (@(posedge clk) disable iff (sys_rst)
      state == clock_ctrl_pkg::ST_SLEEP |=> state != clock_ctrl_pkg::ST_TIMEOUT)
      else $error("wake-up passed through time-out");
   AST_WAKE: assert property (@(posedge clk) disable iff (sys_rst)
      state == clock_ctrl_pkg::ST_SLEEP && rise[clock_ctrl_pkg::PIN_WAKE] && !rstReq |=>
      state != clock_ctrl_pkg::ST_SLEEP)
      else $error("async wake ignored");
   AST_RST_HELD: assert property (@(posedge clk) disable iff (sys_rst)
      state == clock_ctrl_pkg::ST_STARTUP ##1 state == clock_ctrl_pkg::ST_STARTUP |-> internalReset)
      else $error("internal reset released during start-up");
   AST_HOLD_EXIT: assert property (@(posedge clk) disable iff (sys_rst)
      state == clock_ctrl_pkg::ST_HOLD && !rstReq |=>
      state == clock_ctrl_pkg::ST_TIMEOUT || state == clock_ctrl_pkg::ST_STARTUP)
      else $error("hold did not leave after reset release");
   COV_RUN: cover property (@(posedge clk) disable iff (sys_rst) state == clock_ctrl_pkg::ST_RUN);
   COV_SLEEP_WAKE: cover property (@(posedge clk) disable iff (sys_rst)
      state == clock_ctrl_pkg::ST_SLEEP ##1 state == clock_ctrl_pkg::ST_RUN);
   COV_PSAVE_RESTART: cover property (@(posedge clk) disable iff (sys_rst)
      state == clock_ctrl_pkg::ST_SLEEP ##1 state == clock_ctrl_pkg::ST_STARTUP);
   COV_SOFT_RESTART: cover property (@(posedge clk) disable iff (sys_rst)
      restart && state == clock_ctrl_pkg::ST_RUN);
endmodule // clock_source_startup_control
`default_nettype wire

// ### hw/clock_ctrl_pkg.sv
/*
 Constants, field layouts and types for the clock source and start-up control block.
 Assumes one 100 MHz system clock and an APB register port with 32-bit data.
*/
package clock_ctrl_pkg;
   // Source-select codes with fixed meaning
   localparam logic [3:0] SRC_CODE_EXT = 4'h0;
   localparam logic [3:0] SRC_CODE_RSVD = 4'h1;
   localparam logic [3:0] SRC_CODE_RCCAL = 4'h2;
   localparam logic [3:0] SRC_CODE_RC128 = 4'h3;
   // Fuse image; a stored one is unprogrammed
   typedef struct packed {
      logic divFuse;
      logic [1:0] startFuse;
      logic [3:0] srcSel;
   } fuse_t;
   localparam fuse_t FUSE_DEFAULT = '{divFuse: 1'b0, startFuse: 2'h2, srcSel: 4'h2};
   localparam logic FUSE_PROGRAMMED = 1'b0;
   // Oscillator pin indices
   localparam int SRC_LP = 0;
   localparam int SRC_FS = 1;
   localparam int SRC_LF = 2;
   localparam int SRC_RC128 = 3;
   localparam int SRC_RCCAL = 4;
   localparam int SRC_EXT = 5;
   localparam int NUM_SRC = 6;
   // Synchronised pin vector layout
   localparam int PIN_WDT = 6;
   localparam int PIN_ASY = 7;
   localparam int PIN_WAKE = 8;
   localparam int PIN_RST = 9;
   localparam int NUM_PINS = 10;
   // Delay counts in oscillator cycles
   localparam int TOUT_SHORT = 512;
   localparam int TOUT_LONG = 8192;
   localparam int START_EXT = 6;
   localparam int START_258 = 258;
   localparam int START_1K = 1024;
   localparam int START_16K = 16384;
   localparam int START_32K = 32768;
   localparam int CNT_W = 16;
   localparam int DIV_LAST = 7;
   // Register map
   localparam int ADDR_W = 12;
   localparam logic [11:0] REG_FUSE = 12'h000;
   localparam logic [11:0] REG_CTRL = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SLEEP_BIT = 3;
   localparam int CTRL_RESTART_BIT = 4;
   localparam logic [2:0] MODE_RESET = 3'h0;
   // Sleep modes
   typedef enum logic [2:0] {
      SLP_IDLE = 3'h0,
      SLP_ADCNR = 3'h1,
      SLP_PDOWN = 3'h2,
      SLP_PSAVE = 3'h3,
      SLP_STANDBY = 3'h4
   } sleep_mode_t;
   // Control states
   typedef enum logic [2:0] {ST_HOLD, ST_TIMEOUT, ST_STARTUP, ST_RUN, ST_SLEEP} ctl_state_t;
   // Gated clock ticks to the domains
   typedef struct packed {
      logic core;
      logic flash;
      logic periph;
      logic asyncTimer;
      logic converter;
   } clk_ticks_t;
endpackage

// ### dv/osc_source_model.sv
/*
 Behavioural oscillator bank: six clock sources, watchdog oscillator, timer crystal.
 Assumes a free-running system clock far faster than every oscillator here.
*/
`timescale 1ns/10ps
`default_nettype none
module osc_source_model #(
   parameter int SLOW = 0
) (
   input wire logic clk,
   output logic [7:0] osc
);
   // Half periods in clk cycles: sources 0..5, watchdog, timer crystal
   localparam int HALF [8] = '{2, 3, 4, 5, 6, 7, 2, 5};
   int cnt [8];
   // Free-running, like real oscillators; distinct rates tell sources apart
   initial begin
      osc = 8'h00;
      foreach (cnt[i]) cnt[i] = 0;
      forever begin
         @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            cnt[i]++;
            if (cnt[i] >= HALF[i] * (SLOW + 1)) begin
               cnt[i] = 0;
               osc[i] <= ~osc[i];
            end
         end
      end
   end
endmodule // osc_source_model
`default_nettype wire

// ### dv/clock_source_startup_control_tb.sv
/*
 Self-checking bench for the clock source and start-up control block.
 Assumes the oscillator bank model and the design package are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module clock_source_startup_control_tb;
   localparam int TOUT = 16;
   logic clk, sysRst, psel, penable, pwrite, asyncWake, resetSource, clr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic pready, pslverr, internalReset, rerr;
   logic [7:0] osc, prevOsc;
   logic [6:0] f;
   clock_ctrl_pkg::clk_ticks_t clockTicks;
   int mismatches, samples_checked, s, edgeCnt [8], tickCnt [5];

   clock_source_startup_control #(.TOUT_LONG_CYC(TOUT), .START_16K_CYC(20), .START_32K_CYC(24))
   u_clock_source_startup_control (
      .clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .oscillator_amp_input(osc[5:0]), .watchdogOsc(osc[6]), .asyncTimerOsc(osc[7]),
      .asyncWake(asyncWake), .resetSource(resetSource), .internalReset(internalReset),
      .clockTicks(clockTicks));
   osc_source_model u_osc_source_model (.clk(clk), .osc(osc));

   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Oscillator edge and domain tick counters, cleared on request
   always @(posedge clk) begin
      prevOsc <= osc;
      for (int i = 0; i < 8; i++) edgeCnt[i] <= clr ? 0 : edgeCnt[i] + int'(osc[i] & ~prevOsc[i]);
      for (int i = 0; i < 5; i++) tickCnt[i] <= clr ? 0 : tickCnt[i] + int'(clockTicks[i]);
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; waits for pready, no fixed latency assumed
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the bench watchdog ends a stalled transfer
      do @(posedge clk); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic clear_counts(input int cycles);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (cycles) @(posedge clk);
   endtask

   // Waits for release, then checks the watchdog edges spent meanwhile
   task automatic release_check(input int limit);
      int n;
      n = 0;
      while (internalReset !== 1'b0 && n < limit) begin
         @(posedge clk);
         n++;
      end
      check("internalReset released", 32'h0, 32'(internalReset));
      check("time-out length", 32'h1, 32'(edgeCnt[6] inside {[TOUT:TOUT + 24]}));
   endtask

   function automatic int src_of(input logic [3:0] c);
      casez (c)
         4'b1???: return 0;
         4'b011?: return 1;
         4'b010?: return 2;
         4'b0011: return 3;
         4'b0000: return 5;
         default: return 4;
      endcase
   endfunction

   // Expected live domains per sleep mode: core, flash, periph, async, converter
   function automatic logic [31:0] gate_of(input int m);
      case (m)
         0: return 32'h07;
         1: return 32'h03;
         3: return 32'h02;
         default: return 32'h00;
      endcase
   endfunction

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Hang guard, well beyond the worst start-up sum
   initial begin
      #950000;
      mismatches++;
      end_of_test();
   end

   initial begin
      sysRst = 1'b1;
      {psel, penable, pwrite, asyncWake, resetSource, clr} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      void'($urandom(32'h8415));
      repeat (12) @(posedge clk);
      sysRst <= 1'b0;
      clear_counts(0);
      apb(1'b0, clock_ctrl_pkg::REG_FUSE, 32'h0);
      check("FUSE reset", 32'h22, rdata);
      apb(1'b0, clock_ctrl_pkg::REG_STATUS, 32'h0);
      check("STATUS in time-out", 32'h451, rdata);
      apb(1'b0, 12'h00c, 32'h0);
      check("unmapped error", 32'h1, 32'(rerr));
      apb(1'b1, clock_ctrl_pkg::REG_STATUS, 32'hffffffff);
      check("STATUS write error", 32'h1, 32'(rerr));
      release_check(3000);
      clear_counts(480);
      check("divided core ticks", 32'h1, 32'((tickCnt[4] - edgeCnt[4] / 8) inside {[-1:1]}));
      check("flash with core", 32'(tickCnt[4]), 32'(tickCnt[3]));
      $display("test default start-up done");
      for (int m = 0; m < 5; m++) begin
         apb(1'b1, clock_ctrl_pkg::REG_CTRL, 32'(m + 8));
         // Let the last run-state tick drain before counting
         repeat (2) @(posedge clk);
         clear_counts(300);
         check("sleep gating", gate_of(m), {27'h0, tickCnt[4] != 0, tickCnt[3] != 0, tickCnt[2] != 0,
            tickCnt[1] != 0, tickCnt[0] != 0});
         asyncWake <= 1'b1;
         repeat (6) @(posedge clk);
         asyncWake <= 1'b0;
         apb(1'b0, clock_ctrl_pkg::REG_STATUS, 32'h0);
         check("wake state", (m == 2 || m == 3) ? 32'h2 : 32'h3, 32'(rdata[2:0]));
         repeat (200) @(posedge clk);
      end
      $display("test sleep modes done");
      resetSource <= 1'b1;
      repeat (4) @(posedge clk);
      resetSource <= 1'b0;
      clear_counts(8);
      check("reset held", 32'h1, 32'(internalReset));
      release_check(3000);
      $display("test reset source done");
      for (int c = 0; c < 16; c++) begin
         s = $urandom_range(3);
         f = {1'b1, s[1:0], c[3:0]};
         apb(1'b1, clock_ctrl_pkg::REG_FUSE, {25'h0, f});
         apb(1'b1, clock_ctrl_pkg::REG_CTRL, 32'h10);
         repeat (6) @(posedge clk);
         check("restart holds reset", 32'h1, 32'(internalReset));
         s = 0;
         while (internalReset !== 1'b0 && s < 12000) begin
            @(posedge clk);
            s++;
         end
         apb(1'b0, clock_ctrl_pkg::REG_STATUS, 32'h0);
         check("active fuses", {20'h0, f, 5'h03}, rdata);
         clear_counts(400);
         check("selected source", 32'h1,
            32'((tickCnt[4] - edgeCnt[src_of(c[3:0])]) inside {[-2:2]}));
      end
      $display("test source select done");
      end_of_test();
   end
endmodule // clock_source_startup_control_tb
`default_nettype wire
